// *** logic/acpoc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - input clock divided by one to eight
// - retimer enabled straight out of reset
// - locked retimer makes half-period high time
// - retimer inoperative below forty megahertz
// - relock wait after rate change
// - unlocked retimer bypassed, raw duty used at divide-by-one
// - power field 01 gives full power-down
// - outputs high impedance during power-down
// - power-down stops clock; wake grows
// - power field 10 gives faster standby
// - standard or reduced output swing select
// - offset binary, twos complement or gray
// - tristate bit four floats data outputs
// - data appears ten sample clocks later
// - new data after each rising edge
// - data clock out drives capture
// - offset binary codes and clipping
// - twos complement default, top bit flipped
module acpoc_top
  import acpoc_pkg::*;
#(
  parameter int DIVIDE_RESET_M1 = 0,
  parameter int RATE_SCALE = 100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_clk_in,
  input wire logic [DATA_W-1:0] core_sample,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic core_clk_level,
  output logic core_sample_strobe,
  output logic reference_on,
  output logic bias_on,
  output logic awake,
  output logic lvds_reduced_swing,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_out_oe_n,
  output logic sample_capture_clock_out,
  output logic sample_capture_clock_oe_n,
  output logic stream_in_ready,
  output logic stream_valid,
  input wire logic stream_ready,
  output logic [DATA_W-1:0] stream_data
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] power_mode;
  logic retime_en;
  logic [2:0] divide_m1;
  logic [1:0] out_format;
  logic tristate_n_bit;
  logic swing_bit;
  logic locked;
  logic rate_ok;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= POWER_RESET[PWR_LSB +: 2];
    end else if (reg_wr && reg_addr == REG_POWER) begin
      power_mode <= reg_wdata[PWR_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      retime_en <= CLOCK_RESET[CLK_RETIME_EN_BIT];
    end else if (reg_wr && reg_addr == REG_CLOCK) begin
      retime_en <= reg_wdata[CLK_RETIME_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divide_m1 <= 3'(DIVIDE_RESET_M1);
    end else if (reg_wr && reg_addr == REG_DIVIDE) begin
      divide_m1 <= reg_wdata[DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_format <= OUTPUT_RESET[OUT_FMT_LSB +: 2];
      tristate_n_bit <= OUTPUT_RESET[OUT_TRISTATE_BIT];
      swing_bit <= OUTPUT_RESET[OUT_SWING_BIT];
    end else if (reg_wr && reg_addr == REG_OUTPUT) begin
      out_format <= reg_wdata[OUT_FMT_LSB +: 2];
      tristate_n_bit <= reg_wdata[OUT_TRISTATE_BIT];
      swing_bit <= reg_wdata[OUT_SWING_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        REG_POWER: reg_rdata <= {6'h00, power_mode};
        REG_CLOCK: reg_rdata <= {locked, rate_ok, 5'h00, retime_en};
        REG_DIVIDE: reg_rdata <= {5'h00, divide_m1};
        REG_OUTPUT: reg_rdata <= {1'b0, swing_bit, 1'b0, tristate_n_bit,
                                  2'h0, out_format};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign lvds_reduced_swing = swing_bit;

  ////////////////////////////////////////////////////////////////////////
  // power modes

  logic clock_run;
  logic [WAKE_W-1:0] down_time;
  logic [WAKE_W-1:0] wake_cnt;
  logic [1:0] prev_mode;

  always_comb begin
    case (power_mode)
      ACPOC_PWR_DOWN: begin
        clock_run = 1'b0;
        reference_on = 1'b0;
        bias_on = 1'b0;
      end
      ACPOC_PWR_STANDBY: begin
        clock_run = 1'b0;
        reference_on = 1'b1;
        bias_on = 1'b0;
      end
      default: begin
        clock_run = 1'b1;
        reference_on = 1'b1;
        bias_on = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      down_time <= '0;
    end else if (power_mode == ACPOC_PWR_DOWN) begin
      if (down_time != '1) begin
        down_time <= down_time + 1'b1;
      end
    end else if (wake_cnt == '0) begin
      down_time <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_mode <= ACPOC_PWR_NORMAL;
    end else begin
      prev_mode <= power_mode;
    end
  end

  // standby wakes in a fixed short time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt <= '0;
    end else if (!clock_run) begin
      wake_cnt <= '0;
    end else if (prev_mode == ACPOC_PWR_DOWN) begin
      wake_cnt <= WAKE_W'(STANDBY_WAKE_CYC) + (down_time >> DOWN_WAKE_SHIFT);
    end else if (prev_mode == ACPOC_PWR_STANDBY) begin
      wake_cnt <= WAKE_W'(STANDBY_WAKE_CYC);
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - 1'b1;
    end
  end

  assign awake = clock_run && (wake_cnt == '0) && (prev_mode == power_mode);

  ////////////////////////////////////////////////////////////////////////
  // clock divider and duty retimer

  logic div_edge;
  logic div_level;
  logic [PERIOD_W-1:0] period_cnt;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] phase;
  logic [WAKE_W-1:0] relock_cnt;
  logic [2:0] prev_div;

  acpoc_divider u_div (
    .clk(clk),
    .rst_b(rst_b),
    .sample_clk_in(sample_clk_in),
    .run(clock_run),
    .ratio_m1(divide_m1),
    .div_edge(div_edge),
    .div_level(div_level)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_cnt <= '0;
      period <= '0;
      phase <= '0;
      prev_div <= 3'h0;
    end else begin
      prev_div <= divide_m1;
      if (div_edge) begin
        period_cnt <= PERIOD_W'(1);
        period <= period_cnt;
        phase <= '0;
      end else begin
        if (period_cnt != '1) begin
          period_cnt <= period_cnt + 1'b1;
        end
        if (phase != '1) begin
          phase <= phase + 1'b1;
        end
      end
    end
  end

  // scaled period check against 40 MHz
  assign rate_ok = (32'(period) * 32'(CLK_PERIOD_NS)) <=
                   (32'(RETIME_MAX_PERIOD_NS) * 32'(RATE_SCALE));

  // relock wait after any rate change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      relock_cnt <= WAKE_W'(RELOCK_CYC);
    end else if (!clock_run || !retime_en || !rate_ok || prev_div != divide_m1 ||
                 (div_edge && period_cnt != period)) begin
      relock_cnt <= WAKE_W'(RELOCK_CYC);
    end else if (relock_cnt != '0) begin
      relock_cnt <= relock_cnt - 1'b1;
    end
  end

  assign locked = (relock_cnt == '0) && retime_en && rate_ok && clock_run;

  // regenerated falling edge at half period
  always_comb begin
    if (locked) begin
      // edge cycle counts as the first high cycle; extra bit stops wrap
      core_clk_level = div_edge || (({1'b0, phase} + 1'b1) < {1'b0, period >> 1});
    end else begin
      core_clk_level = div_level;
    end
  end

  assign core_sample_strobe = div_edge;

  ////////////////////////////////////////////////////////////////////////
  // pipeline and output coding

  logic [DATA_W-1:0] pipe [PIPE_DEPTH];
  logic [DATA_W-1:0] next_code;
  logic [DATA_W-1:0] ob;

  generate
    for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pipe[i] <= '0;
        end else if (div_edge) begin
          pipe[i] <= (i == 0) ? core_sample : pipe[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // core word is offset binary, clipped
  assign ob = pipe[PIPE_DEPTH-1];

  always_comb begin
    case (out_format)
      ACPOC_FMT_OFFSET: next_code = ob;
      ACPOC_FMT_GRAY: next_code = ob ^ (ob >> 1);
      default: next_code = {~ob[DATA_W-1], ob[DATA_W-2:0]};
    endcase
  end

  logic drive;

  assign drive = awake && !tristate_n_bit;

  // launch one cycle after rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= '0;
    end else if (div_edge) begin
      data_out <= next_code;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_capture_clock_out <= 1'b0;
      data_out_oe_n <= '1;
      sample_capture_clock_oe_n <= 1'b1;
    end else begin
      sample_capture_clock_out <= core_clk_level;
      data_out_oe_n <= {DATA_W{!drive}};
      sample_capture_clock_oe_n <= !drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffered copy of the output stream; a full buffer drops the
  // sample and shows it on stream_in_ready, since the converter
  // core cannot be stalled

  acpoc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(div_edge && awake),
    .in_ready(stream_in_ready),
    .in_data(next_code),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data)
  );

endmodule
`default_nettype wire

// *** common/acpoc_pkg.sv ***
package acpoc_pkg;

  localparam int DATA_W = 14;
  localparam int PIPE_DEPTH = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 40;

  // register offsets
  localparam logic [7:0] REG_POWER = 8'h08;
  localparam logic [7:0] REG_CLOCK = 8'h09;
  localparam logic [7:0] REG_DIVIDE = 8'h0B;
  localparam logic [7:0] REG_OUTPUT = 8'h14;

  // field positions
  localparam int PWR_LSB = 0;
  localparam int CLK_RETIME_EN_BIT = 0;
  localparam int CLK_LOCKED_BIT = 7;
  localparam int CLK_RATE_OK_BIT = 6;
  localparam int DIV_LSB = 0;
  localparam int OUT_FMT_LSB = 0;
  localparam int OUT_TRISTATE_BIT = 4;
  localparam int OUT_SWING_BIT = 6;

  // reset values
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] CLOCK_RESET = 8'h01;
  localparam logic [7:0] DIVIDE_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_RESET = 8'h01;

  typedef enum logic [1:0] {
    ACPOC_PWR_NORMAL = 2'h0,
    ACPOC_PWR_DOWN = 2'h1,
    ACPOC_PWR_STANDBY = 2'h2
  } acpoc_pwr_t;

  typedef enum logic [1:0] {
    ACPOC_FMT_OFFSET = 2'h0,
    ACPOC_FMT_TWOS = 2'h1,
    ACPOC_FMT_GRAY = 2'h2
  } acpoc_fmt_t;

  // timing
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_CYC = (RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STANDBY_WAKE_NS = 1000;
  localparam int STANDBY_WAKE_CYC = (STANDBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOWN_WAKE_SHIFT = 2;
  localparam int RETIME_MIN_MHZ = 40;
  localparam int RETIME_MAX_PERIOD_NS = 1000 / RETIME_MIN_MHZ;
  localparam int PERIOD_W = 12;
  localparam int WAKE_W = 16;

endpackage

// *** logic/acpoc_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module acpoc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  assign in_ready = (count != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  // output stage refills when empty or being taken
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // read data from a register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** logic/acpoc_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
module acpoc_divider
  import acpoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_clk_in,
  input wire logic run,
  input wire logic [2:0] ratio_m1,
  output logic div_edge,
  output logic div_level
);

  logic clk_in_d;
  logic [2:0] cnt;
  logic in_rise;
  logic [2:0] half;

  ////////////////////////////////////////////////////////////////////////
  assign in_rise = sample_clk_in && !clk_in_d;
  assign half = 3'(({1'b0, ratio_m1} + 4'h1) >> 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_in_d <= 1'b0;
    end else begin
      clk_in_d <= sample_clk_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 3'h0;
    end else if (!run) begin
      cnt <= 3'h0;
    end else if (in_rise) begin
      cnt <= (cnt >= ratio_m1) ? 3'h0 : cnt + 3'h1;
    end
  end

  assign div_edge = run && in_rise && (cnt == 3'h0);

  // ratio one passes the raw duty cycle on
  always_comb begin
    if (!run) begin
      div_level = 1'b0;
    end else if (ratio_m1 == 3'h0) begin
      div_level = sample_clk_in;
    end else begin
      div_level = div_edge || (cnt != 3'h0 && cnt < half);
    end
  end

endmodule
`default_nettype wire

// *** sim/acpoc_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module acpoc_checker
  import acpoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic core_clk_level,
  input wire logic core_sample_strobe,
  input wire logic reference_on,
  input wire logic bias_on,
  input wire logic awake,
  input wire logic lvds_reduced_swing,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] data_out_oe_n,
  input wire logic sample_capture_clock_out
);
  logic [1:0] pmode;
  logic ts_q;
  logic sw_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // shadow of the written fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pmode <= 2'h0;
      ts_q <= 1'b0;
      sw_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == REG_POWER)
        pmode <= reg_wdata[1:0];
      if (reg_addr == REG_OUTPUT)
        ts_q <= reg_wdata[OUT_TRISTATE_BIT];
      if (reg_addr == REG_OUTPUT)
        sw_q <= reg_wdata[OUT_SWING_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////
  pd_write_a: assert property (
    reg_wr && reg_addr == REG_POWER && reg_wdata[1:0] == 2'h1 |-> ##[1:2] &data_out_oe_n)
    else $error("power-down write did not float outputs");
  float_hold_a: assert property (
    !awake || ts_q |=> &data_out_oe_n) else $error("outputs driven while off");
  drive_on_a: assert property (
    awake && !ts_q |=> data_out_oe_n == '0) else $error("outputs not driven");
  pd_refs_a: assert property (
    pmode == 2'h1 |-> !reference_on && !bias_on) else $error("power-down left refs on");
  stby_ref_a: assert property (
    pmode == 2'h2 |-> reference_on && !awake) else $error("standby reference wrong");
  normal_on_a: assert property (
    pmode == 2'h0 |-> reference_on && bias_on) else $error("normal mode not powered");
  no_strobe_a: assert property (
    (pmode[0] ^ pmode[1]) && $stable(pmode) |-> !core_sample_strobe)
    else $error("strobe while powered off");
  launch_edge_a: assert property (
    awake && $changed(data_out) |-> $past(core_sample_strobe))
    else $error("data changed without strobe");
  cap_clock_a: assert property (
    awake |=> sample_capture_clock_out == $past(core_clk_level))
    else $error("capture clock not following");
  swing_sel_a: assert property (
    lvds_reduced_swing == sw_q) else $error("swing select wrong");
endmodule
bind acpoc_top acpoc_checker chk_u (
  .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .core_clk_level(core_clk_level),
  .core_sample_strobe(core_sample_strobe), .reference_on(reference_on),
  .bias_on(bias_on), .awake(awake), .lvds_reduced_swing(lvds_reduced_swing),
  .data_out(data_out), .data_out_oe_n(data_out_oe_n),
  .sample_capture_clock_out(sample_capture_clock_out)
);
`default_nettype wire

// *** sim/acpoc_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module acpoc_rx_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic stream_valid,
  output logic stream_ready,
  output int taken
);
  logic slow;
  // receiver takes words
  // half-rate ready keeps the far side slow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slow <= 1'b0;
      stream_ready <= 1'b0;
      taken <= 0;
    end else begin
      slow <= !slow;
      stream_ready <= !stall && slow;
      if (stream_valid && stream_ready)
        taken <= taken + 1;
    end
  end
endmodule
`default_nettype wire

// *** sim/acpoc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module acpoc_top_tb;
  import acpoc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sample_clk_in = 1'b0;
  logic reg_wr = 1'b0;
  logic stall = 1'b0;
  logic run_chk = 1'b0;
  logic stb;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] core_sample = '0;
  logic [7:0] reg_rdata;
  logic core_clk_level, core_sample_strobe, reference_on, bias_on, awake;
  logic lvds_reduced_swing, stream_in_ready, stream_valid, stream_ready;
  logic [DATA_W-1:0] data_out, data_out_oe_n, stream_data;
  logic [1:0] fmt = 2'h1;
  logic [31:0] rnd = 32'd21648;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] bnd[3] = '{14'h0000, 14'h2000, 14'h3FFF};
  logic [7:0] ra[5] = '{8'h08, 8'h09, 8'h0B, 8'h14, 8'h13};
  logic [7:0] rm[5] = '{8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] rv[5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  logic cap_clk_oe_n;
  int mismatches = 0;
  int samples_checked = 0;
  int p_hi = 2;
  int p_lo = 2;
  int taken;
  always #20 clk = ~clk;
  acpoc_top dut_u (.clk(clk), .rst_b(rst_b), .sample_clk_in(sample_clk_in),
    .core_sample(core_sample), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_clk_level(core_clk_level),
    .core_sample_strobe(core_sample_strobe), .reference_on(reference_on),
    .bias_on(bias_on), .awake(awake), .lvds_reduced_swing(lvds_reduced_swing),
    .data_out(data_out), .data_out_oe_n(data_out_oe_n),
    .sample_capture_clock_out(), .sample_capture_clock_oe_n(cap_clk_oe_n),
    .stream_in_ready(stream_in_ready), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data));
  acpoc_rx_model rx_u (.clk(clk), .rst_b(rst_b), .stall(stall),
    .stream_valid(stream_valid), .stream_ready(stream_ready), .taken(taken));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  function automatic logic [DATA_W-1:0] enc(input logic [DATA_W-1:0] s);
    case (fmt)
      2'h0: enc = s;
      2'h2: enc = s ^ (s >> 1);
      default: enc = {~s[DATA_W-1], s[DATA_W-2:0]};
    endcase
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: sig = core_sample_strobe;
      1: sig = core_clk_level;
      2: sig = awake;
      3: sig = stream_in_ready;
      default: sig = stream_valid;
    endcase
  endfunction
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait; running out ends the run
  // sampled on the edge itself, away from the #1 stimulus race
  task automatic till(input int w, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(w) !== v && n < 600);
    #1;
    if (n >= 600) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask
  task automatic hi_run(output int n);
    till(1, 1'b0, n);
    till(1, 1'b1, n);
    till(1, 1'b0, n);
  endtask
  ////////////////////////////////////////////////////////////////
  always begin
    repeat (p_hi) @(posedge clk);
    #1;
    sample_clk_in = 1'b0;
    repeat (p_lo) @(posedge clk);
    #1;
    sample_clk_in = 1'b1;
  end
  // driver notes each captured word
  always @(posedge clk) begin
    if (run_chk && core_sample_strobe === 1'b1)
      exp_q.push_back(enc(core_sample));
    #1;
    rnd = xs(rnd);
    core_sample = exp_q.size() < 3 ? bnd[exp_q.size()] : rnd[13:0];
  end
  always @(posedge clk) begin
    stb = core_sample_strobe;
    #1;
    if (stb === 1'b1 && exp_q.size() > PIPE_DEPTH) begin
      cyc(1);
      chk({data_out_oe_n, data_out}, {14'h0000, exp_q.pop_front()});
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int w[2];
    logic [7:0] d;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk(d & rm[i], rv[i]);
    end
    for (int r = 1; r <= 8; r++) begin
      wr(REG_DIVIDE, 8'(r - 1));
      repeat (3) till(0, 1'b1, n);
      chk(n, r * 4);
    end
    wr(REG_DIVIDE, 8'h00);
    for (int f = 0; f < 3; f++) begin
      wr(REG_OUTPUT, 8'(f));
      fmt = 2'(f);
      exp_q.delete();
      run_chk = 1'b1;
      repeat (16) till(0, 1'b1, n);
      run_chk = 1'b0;
      cyc(8);
    end
    // skewed duty: raw high 2 of 8 cycles
    p_lo = 6;
    cyc(20);
    rd(REG_CLOCK, d);
    chk(d[7], 1'b0);
    hi_run(n);
    chk(n, 2);
    cyc(100);
    rd(REG_CLOCK, d);
    chk(d[7:6], 2'h3);
    hi_run(n);
    chk(n, 4);
    wr(REG_CLOCK, 8'h00);
    cyc(20);
    hi_run(n);
    chk(n, 2);
    wr(REG_CLOCK, 8'h01);
    p_hi = 40;
    p_lo = 40;
    cyc(300);
    rd(REG_CLOCK, d);
    chk(d[7:6], 2'h0);
    p_hi = 2;
    p_lo = 2;
    cyc(100);
    // slow, occasional tristate use only
    wr(REG_OUTPUT, 8'h51);
    chk({lvds_reduced_swing, cap_clk_oe_n, data_out_oe_n}, {2'h3, 14'h3FFF});
    wr(REG_OUTPUT, 8'h01);
    chk({lvds_reduced_swing, cap_clk_oe_n, data_out_oe_n}, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      wr(REG_POWER, 8'h01);
      chk({reference_on, bias_on, awake, &data_out_oe_n, cap_clk_oe_n}, 5'h03);
      cyc(40 + i * 360);
      wr(REG_POWER, 8'h00);
      till(2, 1'b1, w[i]);
    end
    chk(w[1] > w[0], 1);
    chk({reference_on, bias_on, awake}, 3'h7);
    wr(REG_POWER, 8'h02);
    chk({reference_on, awake}, 2'h2);
    cyc(40);
    wr(REG_POWER, 8'h00);
    till(2, 1'b1, n);
    chk(n < w[0], 1);
    stall = 1'b1;
    till(3, 1'b0, n);
    wr(REG_POWER, 8'h02);
    n = taken;
    stall = 1'b0;
    till(4, 1'b0, w[0]);
    chk(taken - n >= FIFO_DEPTH && taken - n <= FIFO_DEPTH + 2, 1);
    test_done();
  end
endmodule
`default_nettype wire
